//--- hdl/rics_pkg.sv
package rics_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int TICK_W = 15;

    localparam logic [15:0] OFF_CAL_CTRL = 16'h0040;
    localparam logic [15:0] OFF_IRQ_EN = 16'h0042;
    localparam logic [15:0] OFF_CTRL_TWO = 16'h0043;
    localparam logic [15:0] OFF_STATUS = 16'h0044;
    localparam logic [15:0] OFF_ALARM_HOUR = 16'h0046;
    localparam logic [15:0] OFF_SECOND = 16'h0047;
    localparam logic [15:0] OFF_MINUTE = 16'h0048;
    localparam logic [15:0] OFF_HOUR = 16'h0049;
    localparam logic [15:0] OFF_DAY = 16'h004A;
    localparam logic [15:0] OFF_SW_DATA = 16'h004F;

    // control_two field positions
    localparam int CT_COMP_EN = 7;
    localparam int CT_SW_CLEAR = 3;
    localparam int CT_SW_EN = 2;
    localparam int CT_MOD_EN = 1;
    localparam int CT_FAST = 0;

    // status and enable bit positions
    localparam int EV_ALARM = 7;
    localparam int EV_SW = 6;
    localparam int EV_DAY = 5;
    localparam int EV_HOUR = 4;
    localparam int EV_MINUTE = 3;
    localparam int EV_SECOND = 2;
    localparam int EV_TICK1 = 1;
    localparam int EV_TICK2 = 0;

    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] SW_DATA_RESET = 8'h00;
    localparam logic [7:0] SW_DATA_MAX = 8'h63;

    localparam logic [1:0] WE_ARM = 2'h2;
    localparam logic [1:0] WE_STEP1 = 2'h0;
    localparam logic [1:0] WE_STEP2 = 2'h1;
    localparam logic [1:0] WE_STEP3 = 2'h3;

    // tick periods, counted in crystal clock cycles
    localparam longint XTAL_HZ = 32768;
    localparam longint US_PER_S = 1000000;
    localparam longint SW_TICKS_PER_S = 128;
    localparam longint TB1_SLOW_US = 500000;
    localparam longint TB1_FAST_US = 125000;
    localparam longint TB2_SLOW_US = 250000;
    localparam longint TB2_FAST_US = 62500;
    localparam int SW_CNT = int'(XTAL_HZ / SW_TICKS_PER_S);
    localparam int TB1_SLOW_CNT = int'(XTAL_HZ * TB1_SLOW_US / US_PER_S);
    localparam int TB1_FAST_CNT = int'(XTAL_HZ * TB1_FAST_US / US_PER_S);
    localparam int TB2_SLOW_CNT = int'(XTAL_HZ * TB2_SLOW_US / US_PER_S);
    localparam int TB2_FAST_CNT = int'(XTAL_HZ * TB2_FAST_US / US_PER_S);

    typedef enum logic [2:0] {
        WP_OPEN,
        WP_ARMED,
        WP_LOCKED,
        WP_UN1,
        WP_UN2,
        WP_UN3
    } rics_wp_t;

endpackage : rics_pkg

//--- hdl/rics_tick_gen.sv
`timescale 1ns/10ps
module rics_tick_gen #(
    parameter int CW = 15
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic step,
    input wire logic sel_fast,
    input wire logic [CW-1:0] last_slow,
    input wire logic [CW-1:0] last_fast,
    output logic tick
);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [CW-1:0] last;

    always_comb begin
        last = sel_fast ? last_fast : last_slow;
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (step) begin
            // a rate change mid-period takes effect at once; a count already at or past the new limit wraps on the next step
            if (cnt_reg >= last) begin
                cnt_next = '0;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick = tick_reg;

endmodule : rics_tick_gen

//--- hdl/rics_top.sv
`timescale 1ns/10ps
// Behaviour
// - enable register at 0x0042, eight read/write enables, cleared by reset.
// - interrupt request whenever a flag and its enable are both set.
// - compensation enable kept through ordinary reset, cleared only at power-on.
// - writes to compensation and module enable ignored while protected.
// - stopwatch clear writes zero to counter, self-clears, reads zero.
// - stopwatch enable low holds the count; reset clears the enable.
// - module enable gates all activity without changing register contents.
// - fast select picks 0.125/0.0625 s ticks, else 0.5/0.25 s.
// - alarm flag set on match, cleared by status read then alarm hour read.
// - stopwatch flag set each 1/128 s tick, cleared via stopwatch data read.
// - day flag set per day increment, cleared via day register read.
// - hour flag set per hour increment, cleared via hour register read.
// - minute flag set per minute increment, cleared via minute register read.
// - second flag set per second increment, cleared via second register read.
// - timebase 1 flag set per tick, cleared via stopwatch data read.
// - timebase 2 flag set per tick, cleared via stopwatch data read.
// - tick generators run from the uncompensated crystal clock.
// - two writes of 2 to the write-enable field arm protection.
// - writes 0, 1, 3, 2 in order lift protection.
// - protection is inactive after any reset.
module rics_top #(
    parameter int SW_CNT = rics_pkg::SW_CNT,
    parameter int TB1_SLOW_CNT = rics_pkg::TB1_SLOW_CNT,
    parameter int TB1_FAST_CNT = rics_pkg::TB1_FAST_CNT,
    parameter int TB2_SLOW_CNT = rics_pkg::TB2_SLOW_CNT,
    parameter int TB2_FAST_CNT = rics_pkg::TB2_FAST_CNT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    input wire logic crystal_clock,
    input wire logic [rics_pkg::ADDR_W-1:0] addr,
    input wire logic [rics_pkg::DATA_W-1:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic alarm_event,
    input wire logic day_event,
    input wire logic hour_event,
    input wire logic minute_event,
    input wire logic second_event,
    output logic [rics_pkg::DATA_W-1:0] rd_data,
    output logic cpu_irq,
    output logic compensation_enable,
    output logic clock_module_enable,
    output logic write_protect_active,
    output logic [7:0] stopwatch_data
);

    localparam int TW = rics_pkg::TICK_W;

    // crystal clock synchroniser and edge detect
    logic xtal_meta_reg;
    logic xtal_sync_reg;
    logic xtal_last_reg;
    logic xtal_step;

    always_comb begin
        xtal_step = xtal_sync_reg && !xtal_last_reg;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            xtal_meta_reg <= 1'b0;
            xtal_sync_reg <= 1'b0;
            xtal_last_reg <= 1'b0;
        end else begin
            xtal_meta_reg <= crystal_clock;
            xtal_sync_reg <= xtal_meta_reg;
            xtal_last_reg <= xtal_sync_reg;
        end
    end

    // register state
    logic [7:0] irq_en_reg;
    logic [7:0] irq_en_next;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] seen_reg;
    logic [7:0] seen_next;
    logic [7:0] sw_data_reg;
    logic [7:0] sw_data_next;
    logic sw_en_reg;
    logic sw_en_next;
    logic mod_en_reg;
    logic mod_en_next;
    logic fast_reg;
    logic fast_next;
    logic comp_en_reg;
    logic comp_en_next;
    logic irq_reg;
    logic irq_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rst_any;
    logic wp_reg;
    logic wp_next;
    rics_pkg::rics_wp_t wp_state_reg;
    rics_pkg::rics_wp_t wp_state_next;

    // bus decode and flag sources
    logic wr_irq_en;
    logic wr_ctrl_two;
    logic wr_we_field;
    logic [1:0] we_val;
    logic rd_status;
    logic sw_clear_stb;
    logic base_step;
    logic sw_step;
    logic sw_gen_rst;
    logic sw_tick;
    logic tick1;
    logic tick2;
    logic [7:0] set_mask;
    logic [7:0] consumed;
    logic [7:0] clear_mask;

    // the stopwatch divider has no rate select, so both limits are equal
    localparam logic [TW-1:0] SW_LAST = TW'(SW_CNT - 1);
    localparam logic [TW-1:0] TB1_SLOW_LAST = TW'(TB1_SLOW_CNT - 1);
    localparam logic [TW-1:0] TB1_FAST_LAST = TW'(TB1_FAST_CNT - 1);
    localparam logic [TW-1:0] TB2_SLOW_LAST = TW'(TB2_SLOW_CNT - 1);
    localparam logic [TW-1:0] TB2_FAST_LAST = TW'(TB2_FAST_CNT - 1);

    // power-on also clears everything that ordinary reset clears except the crystal synchroniser flops
    always_comb begin
        rst_any = rst || por;
        wr_irq_en = wr_stb && (addr == rics_pkg::OFF_IRQ_EN);
        wr_ctrl_two = wr_stb && (addr == rics_pkg::OFF_CTRL_TWO);
        wr_we_field = wr_stb && (addr == rics_pkg::OFF_CAL_CTRL);
        we_val = wr_data[1:0];
        rd_status = rd_stb && (addr == rics_pkg::OFF_STATUS);
        sw_clear_stb = wr_ctrl_two && wr_data[rics_pkg::CT_SW_CLEAR];
        // dividers count raw crystal edges, never the compensated second
        base_step = xtal_step && mod_en_reg;
        sw_step = base_step && sw_en_reg;
        sw_gen_rst = rst_any || sw_clear_stb;
    end

    rics_tick_gen #(.CW(TW)) sw_gen_u (
        .mclk(mclk), .rst(sw_gen_rst), .step(sw_step), .sel_fast(1'b0),
        .last_slow(SW_LAST), .last_fast(SW_LAST), .tick(sw_tick)
    );

    rics_tick_gen #(.CW(TW)) tb1_gen_u (
        .mclk(mclk), .rst(rst_any), .step(base_step), .sel_fast(fast_reg),
        .last_slow(TB1_SLOW_LAST), .last_fast(TB1_FAST_LAST), .tick(tick1)
    );

    rics_tick_gen #(.CW(TW)) tb2_gen_u (
        .mclk(mclk), .rst(rst_any), .step(base_step), .sel_fast(fast_reg),
        .last_slow(TB2_SLOW_LAST), .last_fast(TB2_FAST_LAST), .tick(tick2)
    );

    always_comb begin
        set_mask = 8'h00;
        consumed = 8'h00;
        if (mod_en_reg) begin
            set_mask[rics_pkg::EV_ALARM] = alarm_event;
            set_mask[rics_pkg::EV_DAY] = day_event;
            set_mask[rics_pkg::EV_HOUR] = hour_event;
            set_mask[rics_pkg::EV_MINUTE] = minute_event;
            set_mask[rics_pkg::EV_SECOND] = second_event;
        end
        set_mask[rics_pkg::EV_SW] = sw_tick;
        set_mask[rics_pkg::EV_TICK1] = tick1;
        set_mask[rics_pkg::EV_TICK2] = tick2;
        if (rd_stb) begin
            if (addr == rics_pkg::OFF_ALARM_HOUR) begin
                consumed[rics_pkg::EV_ALARM] = 1'b1;
            end
            if (addr == rics_pkg::OFF_SW_DATA) begin
                consumed[rics_pkg::EV_SW] = 1'b1;
                consumed[rics_pkg::EV_TICK1] = 1'b1;
                consumed[rics_pkg::EV_TICK2] = 1'b1;
            end
            if (addr == rics_pkg::OFF_DAY) begin
                consumed[rics_pkg::EV_DAY] = 1'b1;
            end
            if (addr == rics_pkg::OFF_HOUR) begin
                consumed[rics_pkg::EV_HOUR] = 1'b1;
            end
            if (addr == rics_pkg::OFF_MINUTE) begin
                consumed[rics_pkg::EV_MINUTE] = 1'b1;
            end
            if (addr == rics_pkg::OFF_SECOND) begin
                consumed[rics_pkg::EV_SECOND] = 1'b1;
            end
        end
        // only flags that the status read showed may be consumed
        clear_mask = consumed & seen_reg;
        // an event in the clearing cycle wins over the clear
        flags_next = (flags_reg & ~clear_mask) | set_mask;
        seen_next = seen_reg & ~consumed;
        if (rd_status) begin
            seen_next = flags_reg;
        end
    end

    always_comb begin
        irq_en_next = irq_en_reg;
        comp_en_next = comp_en_reg;
        mod_en_next = mod_en_reg;
        sw_en_next = sw_en_reg;
        fast_next = fast_reg;
        if (wr_irq_en) begin
            irq_en_next = wr_data;
        end
        if (wr_ctrl_two) begin
            sw_en_next = wr_data[rics_pkg::CT_SW_EN];
            fast_next = wr_data[rics_pkg::CT_FAST];
            if (!wp_reg) begin
                comp_en_next = wr_data[rics_pkg::CT_COMP_EN];
                mod_en_next = wr_data[rics_pkg::CT_MOD_EN];
            end
        end
        // status writes decode to nothing, so the flags cannot be touched
        irq_next = |(flags_next & irq_en_next);
    end

    always_comb begin
        sw_data_next = sw_data_reg;
        if (sw_clear_stb) begin
            sw_data_next = rics_pkg::SW_DATA_RESET;
        end else if (sw_tick && sw_en_reg) begin
            if (sw_data_reg >= rics_pkg::SW_DATA_MAX) begin
                sw_data_next = rics_pkg::SW_DATA_RESET;
            end else begin
                sw_data_next = sw_data_reg + 8'h01;
            end
        end
    end

    // a wrong value mid-unlock falls back to locked, so stray writes never open it
    always_comb begin
        wp_state_next = wp_state_reg;
        if (wr_we_field) begin
            unique case (wp_state_reg)
                rics_pkg::WP_OPEN: wp_state_next = (we_val == rics_pkg::WE_ARM) ?
                    rics_pkg::WP_ARMED : rics_pkg::WP_OPEN;
                rics_pkg::WP_ARMED: wp_state_next = (we_val == rics_pkg::WE_ARM) ?
                    rics_pkg::WP_LOCKED : rics_pkg::WP_OPEN;
                rics_pkg::WP_LOCKED: wp_state_next = (we_val == rics_pkg::WE_STEP1) ?
                    rics_pkg::WP_UN1 : rics_pkg::WP_LOCKED;
                rics_pkg::WP_UN1: wp_state_next = (we_val == rics_pkg::WE_STEP2) ?
                    rics_pkg::WP_UN2 : rics_pkg::WP_LOCKED;
                rics_pkg::WP_UN2: wp_state_next = (we_val == rics_pkg::WE_STEP3) ?
                    rics_pkg::WP_UN3 : rics_pkg::WP_LOCKED;
                rics_pkg::WP_UN3: wp_state_next = (we_val == rics_pkg::WE_ARM) ?
                    rics_pkg::WP_OPEN : rics_pkg::WP_LOCKED;
                default: wp_state_next = rics_pkg::WP_LOCKED;
            endcase
        end
        wp_next = (wp_state_next != rics_pkg::WP_OPEN) && (wp_state_next != rics_pkg::WP_ARMED);
    end

    always_comb begin
        rd_data_next = 8'h00;
        if (rd_stb) begin
            if (addr == rics_pkg::OFF_IRQ_EN) begin
                rd_data_next = irq_en_reg;
            end else if (addr == rics_pkg::OFF_CTRL_TWO) begin
                // the clear bit always reads back as zero
                rd_data_next[rics_pkg::CT_COMP_EN] = comp_en_reg;
                rd_data_next[rics_pkg::CT_SW_EN] = sw_en_reg;
                rd_data_next[rics_pkg::CT_MOD_EN] = mod_en_reg;
                rd_data_next[rics_pkg::CT_FAST] = fast_reg;
            end else if (addr == rics_pkg::OFF_STATUS) begin
                rd_data_next = flags_reg;
            end else if (addr == rics_pkg::OFF_SW_DATA) begin
                rd_data_next = sw_data_reg;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst_any) begin
            irq_en_reg <= rics_pkg::IRQ_EN_RESET;
            flags_reg <= rics_pkg::FLAGS_RESET;
            seen_reg <= 8'h00;
            sw_data_reg <= rics_pkg::SW_DATA_RESET;
            sw_en_reg <= 1'b0;
            mod_en_reg <= 1'b0;
            fast_reg <= 1'b0;
            irq_reg <= 1'b0;
            rd_data_reg <= 8'h00;
            wp_state_reg <= rics_pkg::WP_OPEN;
            wp_reg <= 1'b0;
        end else begin
            irq_en_reg <= irq_en_next;
            flags_reg <= flags_next;
            seen_reg <= seen_next;
            sw_data_reg <= sw_data_next;
            sw_en_reg <= sw_en_next;
            mod_en_reg <= mod_en_next;
            fast_reg <= fast_next;
            irq_reg <= irq_next;
            rd_data_reg <= rd_data_next;
            wp_state_reg <= wp_state_next;
            wp_reg <= wp_next;
        end
    end

    // compensation survives ordinary reset; only power-on clears it
    always_ff @(posedge mclk) begin
        if (por) begin
            comp_en_reg <= 1'b0;
        end else begin
            comp_en_reg <= comp_en_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign cpu_irq = irq_reg;
    assign compensation_enable = comp_en_reg;
    assign clock_module_enable = mod_en_reg;
    assign write_protect_active = wp_reg;
    assign stopwatch_data = sw_data_reg;

    sequence s_arm_second;
        wr_we_field && (we_val == rics_pkg::WE_ARM) && (wp_state_reg == rics_pkg::WP_ARMED);
    endsequence

    sequence s_unlock_last;
        wr_we_field && (we_val == rics_pkg::WE_ARM) && (wp_state_reg == rics_pkg::WP_UN3);
    endsequence

    a_arm_locks: assert property (@(posedge mclk) disable iff (rst_any)
        s_arm_second |=> wp_reg)
        else $error("protection not armed by second arm write");
    a_unlock_opens: assert property (@(posedge mclk) disable iff (rst_any)
        s_unlock_last |=> !wp_reg)
        else $error("protection not lifted by unlock sequence");
    a_reset_clears: assert property (@(posedge mclk)
        rst_any |=> (!wp_reg && (flags_reg == 8'h00)))
        else $error("reset left protection or flags set");
    a_protect_holds: assert property (@(posedge mclk) disable iff (rst_any)
        (wp_reg && wr_ctrl_two) |=> ($stable(comp_en_reg) && $stable(mod_en_reg)))
        else $error("protected bit changed by write");
    a_irq_request: assert property (@(posedge mclk) disable iff (rst_any)
        cpu_irq == (|(flags_reg & irq_en_reg)))
        else $error("interrupt request does not match flags and enables");
    a_sw_clear_zero: assert property (@(posedge mclk) disable iff (rst_any)
        sw_clear_stb |=> (sw_data_reg == 8'h00))
        else $error("stopwatch data not cleared");
    a_sw_hold: assert property (@(posedge mclk) disable iff (rst_any)
        (!sw_en_reg && !sw_clear_stb) |=> $stable(sw_data_reg))
        else $error("stopwatch data moved while disabled");
    a_second_sets: assert property (@(posedge mclk) disable iff (rst_any)
        (mod_en_reg && second_event) |=> flags_reg[rics_pkg::EV_SECOND])
        else $error("second flag not set by event");

endmodule : rics_top

//--- dv/rics_top_tb_top.sv
`timescale 1ns/10ps
module rics_top_tb_top;
logic mclk = 1'b0;
logic rst = 1'b1;
logic por = 1'b1;
logic xt = 1'b0;
logic wr_stb = 1'b0;
logic rd_stb = 1'b0;
logic [15:0] addr = 16'h0000;
logic [7:0] wr_data = 8'h00;
logic [4:0] ev = 5'h00;
logic [7:0] rd_data;
logic [7:0] sw;
logic [7:0] d;
logic irq, comp, mod, wp;
int num_errors = 0;
int cmp_count = 0;
always #12.5 mclk = ~mclk;
always @(posedge mclk) xt <= ~xt;
rics_top #(.SW_CNT(4), .TB1_SLOW_CNT(16), .TB1_FAST_CNT(4), .TB2_SLOW_CNT(8),
    .TB2_FAST_CNT(2)) dut_u (.mclk(mclk), .rst(rst), .por(por), .crystal_clock(xt),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .alarm_event(ev[4]), .day_event(ev[3]), .hour_event(ev[2]), .minute_event(ev[1]),
    .second_event(ev[0]), .rd_data(rd_data), .cpu_irq(irq), .compensation_enable(comp),
    .clock_module_enable(mod), .write_protect_active(wp), .stopwatch_data(sw));
task wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    // let the flops settle before any compare of the written state
    @(negedge mclk);
endtask : wr
// read data stand only in the cycle after the strobe
task rd(input logic [15:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rd_data;
endtask : rd
task chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
        num_errors++;
        $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
endtask : chk
task pulse(input int i);
    @(posedge mclk);
    ev[i] <= 1'b1;
    @(posedge mclk);
    ev[i] <= 1'b0;
endtask : pulse
task give_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask : give_verdict
initial begin
    #1000000;
    num_errors++;
    give_verdict();
end
initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    por <= 1'b0;
    rd(rics_pkg::OFF_IRQ_EN);
    chk(d, 8'h00);
    wr(rics_pkg::OFF_IRQ_EN, 8'hFF);
    rd(rics_pkg::OFF_IRQ_EN);
    chk(d, 8'hFF);
    // only the second enable stays set so running ticks leave the request alone
    wr(rics_pkg::OFF_IRQ_EN, 8'h04);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h02);
    pulse(0);
    rd(rics_pkg::OFF_STATUS);
    chk(d & 8'hBC, 8'h04);
    chk({7'h00, irq}, 8'h01);
    wr(rics_pkg::OFF_STATUS, 8'h00);
    rd(rics_pkg::OFF_STATUS);
    pulse(1);
    rd(rics_pkg::OFF_SECOND);
    rd(rics_pkg::OFF_STATUS);
    chk(d & 8'hBC, 8'h08);
    chk({7'h00, irq}, 8'h00);
    rd(rics_pkg::OFF_MINUTE);
    rd(rics_pkg::OFF_STATUS);
    chk(d & 8'hBC, 8'h00);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h83);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h02);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h02);
    chk({7'h00, wp}, 8'h01);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h00);
    chk({6'h00, comp, mod}, 8'h03);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h00);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h01);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h03);
    wr(rics_pkg::OFF_CAL_CTRL, 8'h02);
    chk({7'h00, wp}, 8'h00);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h80);
    chk({6'h00, comp, mod}, 8'h02);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({6'h00, comp, wp}, 8'h02);
    rd(rics_pkg::OFF_CTRL_TWO);
    chk(d & 8'h0F, 8'h00);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h06);
    repeat (60) @(posedge mclk);
    chk({7'h00, sw != 8'h00}, 8'h01);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h0A);
    repeat (30) @(posedge mclk);
    chk(sw, 8'h00);
    wr(rics_pkg::OFF_IRQ_EN, 8'h02);
    wr(rics_pkg::OFF_CTRL_TWO, 8'h03);
    repeat (20) @(posedge mclk);
    rd(rics_pkg::OFF_STATUS);
    chk(d & 8'h03, 8'h03);
    chk({7'h00, irq}, 8'h01);
    give_verdict();
end
endmodule : rics_top_tb_top
